// [shared/lfsr_seed_dither_frm_defines.vh]
`ifndef LFSR_SEED_DITHER_FRM_DEFINES_VH
`define LFSR_SEED_DITHER_FRM_DEFINES_VH

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define AXI_AW        12
`define IDX_LSB       2
`define IDX_MSB       9
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

// ----------------------------------------
// Register indexes (byte address = 4 * index)
// ----------------------------------------
`define IDX_CTL       8'h02
`define IDX_RED       8'h20
`define IDX_GRN       8'h22
`define IDX_BLU       8'h24
`define IDX_RSV_LO    8'h26
`define IDX_RSV_LO_E  8'h7F
`define IDX_DITH      8'h80
`define IDX_DITH_E    8'h9F
`define IDX_RSV_HI    8'hA0
`define IDX_RSV_HI_E  8'hBF
`define IDX_FRM       8'hC0
`define IDX_FRM_E     8'hFF

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SEED_W        15
`define RST_RED       15'h00AA
`define RST_GRN       15'h0032
`define RST_BLU       15'h0000
`define CTL_W         4
`define RST_CTL       4'h0
`define CTL_COL_LSB   0
`define CTL_COL_MSB   1
`define CTL_BLK_LSB   2
`define CTL_BLK_MSB   3
`define COL_RED       2'h0
`define COL_GRN       2'h1
`define COL_BLU       2'h2
`define COL_NONE      2'h3

// ----------------------------------------
// Pattern memories
// ----------------------------------------
`define DITH_AW       7
`define DITH_DEPTH    96
`define FRM_AW        10
`define FRM_DEPTH     768

`endif

// [hw/seed_reg.v]
`timescale 1ns/1ps
`include "lfsr_seed_dither_frm_defines.vh"

// ----------------------------------------
// One LFSR seed with byte-lane writes
// ----------------------------------------
module seed_reg #(
  parameter [`SEED_W-1:0] RESET_VAL = 15'h0000
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire              we_lo,     // Write bits 7:0
  input  wire              we_hi,     // Write bits 14:8
  input  wire [7:0]        din_lo,
  input  wire [7:0]        din_hi,
  output reg  [`SEED_W-1:0] seed_q
);

  // Reserved bit 15 is not stored; it always reads back zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      seed_q <= RESET_VAL;
    end else begin
      if (we_lo) begin
        seed_q[7:0] <= din_lo;
      end
      if (we_hi) begin
        seed_q[14:8] <= din_hi[6:0];
      end
    end
  end

endmodule

// [hw/pattern_mem.v]
`timescale 1ns/1ps
`include "lfsr_seed_dither_frm_defines.vh"

// ----------------------------------------
// Byte memory, one write port, two read ports
// ----------------------------------------
module pattern_mem #(
  parameter AW    = 7,
  parameter DEPTH = 96
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [7:0]    wdata,
  input  wire [AW-1:0] raddr_a,   // Register side
  input  wire [AW-1:0] raddr_b,   // Pixel side
  output reg  [7:0]    rdata_a_q,
  output reg  [7:0]    rdata_b_q
);

  reg [7:0] mem [0:DEPTH-1];     // Pattern contents, no reset

  // Write port; addresses past the depth are dropped
  always @(posedge aclk) begin
    if (we && (waddr < DEPTH)) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered reads; out of range reads as zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      rdata_a_q <= 8'h00;
      rdata_b_q <= 8'h00;
    end else begin
      rdata_a_q <= (raddr_a < DEPTH) ? mem[raddr_a] : 8'h00;
      rdata_b_q <= (raddr_b < DEPTH) ? mem[raddr_b] : 8'h00;
    end
  end

endmodule

// [hw/lfsr_seed_dither_frm_regs.v]
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "lfsr_seed_dither_frm_defines.vh"

// Overview of operation
// RQ1 - Red seed, 15 bits, resets to 00AA
// RQ2 - Green seed, 15 bits, resets to 0032
// RQ3 - Blue seed, 15 bits, resets to zero
// RQ4 - Software writes seed bit 15 as zero
// RQ5 - Byte window 80-9F reaches dither memory
// RQ6 - Sixteen 4x4 dither levels per colour
// RQ7 - Colour select picks dither memory colour
// RQ8 - Window C0-FF reaches frame modulation memory
// RQ9 - Four modulation blocks, select picks one
// RQ10 - Colour select picks modulation memory colour
// RQ11 - Reserved ranges read zero, ignore writes
module lfsr_seed_dither_frm_regs (
  input  wire               aclk,
  input  wire               aresetn,
  // AXI4-Lite write address
  input  wire [`AXI_AW-1:0] s_axi_awaddr,
  input  wire [2:0]         s_axi_awprot,
  input  wire               s_axi_awvalid,
  output reg                s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output reg                s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]         s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  // AXI4-Lite read address
  input  wire [`AXI_AW-1:0] s_axi_araddr,
  input  wire [2:0]         s_axi_arprot,
  input  wire               s_axi_arvalid,
  output reg                s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  // Seeds toward the modulation LFSRs
  output wire [`SEED_W-1:0] red_seed,
  output wire [`SEED_W-1:0] green_seed,
  output wire [`SEED_W-1:0] blue_seed,
  // Pixel-side pattern lookups
  input  wire [`DITH_AW-1:0] dith_px_addr,
  output wire [7:0]          dith_px_data,
  input  wire [`FRM_AW-1:0]  frm_px_addr,
  output wire [7:0]          frm_px_data
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Index falls inside an inclusive window
  function in_win;
    input [7:0] idx;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_win = (idx >= lo) && (idx <= hi);
    end
  endfunction

  // Address lies inside the decoded 256-word space
  function addr_ok;
    input [`AXI_AW-1:0] a;
    begin
      addr_ok = (a[`AXI_AW-1:`IDX_MSB+1] == 2'h0);
    end
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [`AXI_AW-1:0] aw_addr_q;   // Held write address
  reg                aw_have_q;   // Write address taken
  reg  [31:0]        w_data_q;    // Held write data
  reg  [3:0]         w_strb_q;    // Held byte strobes
  reg                w_have_q;    // Write data taken
  reg  [`AXI_AW-1:0] rd_addr_q;   // Held read address
  reg                rd_p1_q;     // Read stage 1: memory lookup
  reg                rd_p2_q;     // Read stage 2: data mux
  reg  [`CTL_W-1:0]  ctl_q;       // Colour and block select
  reg  [31:0]        rdata_d;     // Read mux result
  wire               wr_go;       // Both halves of a write present
  wire               wr_ok;       // Write address inside the map
  wire [7:0]         wr_idx;      // Write register index
  wire [7:0]         rd_idx;      // Read register index
  wire               rd_ok;       // Read address inside the map
  wire [1:0]         col;         // Selected colour component
  wire [1:0]         blk;         // Selected modulation block
  wire               col_ok;      // Colour code names a real memory
  wire               dith_we;     // Dither memory write
  wire               frm_we;      // Modulation memory write
  wire [7:0]         dith_bus_q;  // Dither byte for the bus
  wire [7:0]         frm_bus_q;   // Modulation byte for the bus
  wire [2:0]         seed_lo_we;  // Low byte write per colour
  wire [2:0]         seed_hi_we;  // High byte write per colour
  wire [7:0]         seed_hi_din; // High byte source lane

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign wr_idx = aw_addr_q[`IDX_MSB:`IDX_LSB];
  assign rd_idx = rd_addr_q[`IDX_MSB:`IDX_LSB];
  assign wr_ok  = addr_ok(aw_addr_q);
  assign rd_ok  = addr_ok(rd_addr_q);
  assign wr_go  = aw_have_q && w_have_q && !s_axi_bvalid;
  assign col    = ctl_q[`CTL_COL_MSB:`CTL_COL_LSB];
  assign blk    = ctl_q[`CTL_BLK_MSB:`CTL_BLK_LSB];
  // Code 3 selects nothing, so window accesses then do nothing
  assign col_ok = (col != `COL_NONE);

  // ----------------------------------------
  // Write channel handshakes
  // ----------------------------------------

  // Address and data are taken in either order and held
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q     <= {`AXI_AW{1'b0}};
      aw_have_q     <= 1'b0;
      s_axi_awready <= 1'b0;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      w_have_q      <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      // Address channel
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (wr_go) begin
        aw_have_q     <= 1'b0;
      end else if (!aw_have_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      // Data channel
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (wr_go) begin
        w_have_q     <= 1'b0;
      end else if (!w_have_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Response is raised on the same edge as the commit and waits for bready
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control select register
  // ----------------------------------------

  // Colour select steers both windows; block select steers the modulation window
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= `RST_CTL;
    end else if (wr_go && wr_ok && (wr_idx == `IDX_CTL) && w_strb_q[0]) begin
      ctl_q <= w_data_q[`CTL_W-1:0];
    end
  end

  // ----------------------------------------
  // Seed registers
  // ----------------------------------------

  // Word at the even index carries both bytes on lanes 0 and 1;
  // the odd index is a byte view of the upper half on lane 0
  assign seed_lo_we[0] = wr_go && wr_ok && (wr_idx == `IDX_RED) && w_strb_q[0];
  assign seed_lo_we[1] = wr_go && wr_ok && (wr_idx == `IDX_GRN) && w_strb_q[0];
  assign seed_lo_we[2] = wr_go && wr_ok && (wr_idx == `IDX_BLU) && w_strb_q[0];
  assign seed_hi_we[0] = wr_go && wr_ok && (((wr_idx == `IDX_RED) && w_strb_q[1]) ||
                         ((wr_idx == `IDX_RED + 8'h01) && w_strb_q[0]));
  assign seed_hi_we[1] = wr_go && wr_ok && (((wr_idx == `IDX_GRN) && w_strb_q[1]) ||
                         ((wr_idx == `IDX_GRN + 8'h01) && w_strb_q[0]));
  assign seed_hi_we[2] = wr_go && wr_ok && (((wr_idx == `IDX_BLU) && w_strb_q[1]) ||
                         ((wr_idx == `IDX_BLU + 8'h01) && w_strb_q[0]));
  // Bit 15 of what software writes is simply not stored
  assign seed_hi_din = wr_idx[0] ? w_data_q[7:0] : w_data_q[15:8]; // RQ4

  // Red seed
  seed_reg #(.RESET_VAL(`RST_RED)) u_red_seed ( // RQ1
    .aclk    (aclk),
    .aresetn (aresetn),
    .we_lo   (seed_lo_we[0]),
    .we_hi   (seed_hi_we[0]),
    .din_lo  (w_data_q[7:0]),
    .din_hi  (seed_hi_din),
    .seed_q  (red_seed)
  );

  // Green seed
  seed_reg #(.RESET_VAL(`RST_GRN)) u_green_seed ( // RQ2
    .aclk    (aclk),
    .aresetn (aresetn),
    .we_lo   (seed_lo_we[1]),
    .we_hi   (seed_hi_we[1]),
    .din_lo  (w_data_q[7:0]),
    .din_hi  (seed_hi_din),
    .seed_q  (green_seed)
  );

  // Blue seed
  seed_reg #(.RESET_VAL(`RST_BLU)) u_blue_seed ( // RQ3
    .aclk    (aclk),
    .aresetn (aresetn),
    .we_lo   (seed_lo_we[2]),
    .we_hi   (seed_hi_we[2]),
    .din_lo  (w_data_q[7:0]),
    .din_hi  (seed_hi_din),
    .seed_q  (blue_seed)
  );

  // ----------------------------------------
  // Pattern memories
  // ----------------------------------------

  // Only lane 0 carries a window byte; reserved gaps never write
  assign dith_we = wr_go && wr_ok && w_strb_q[0] && col_ok &&
                   in_win(wr_idx, `IDX_DITH, `IDX_DITH_E); // RQ5 RQ7
  assign frm_we  = wr_go && wr_ok && w_strb_q[0] && col_ok &&
                   in_win(wr_idx, `IDX_FRM, `IDX_FRM_E); // RQ8 RQ10

  // 32 bytes per colour hold 16 levels of 4x4 one-bit cells
  pattern_mem #(.AW(`DITH_AW), .DEPTH(`DITH_DEPTH)) u_dith_mem ( // RQ6
    .aclk      (aclk),
    .aresetn   (aresetn),
    .we        (dith_we),
    .waddr     ({col, wr_idx[4:0]}), // RQ7
    .wdata     (w_data_q[7:0]),
    .raddr_a   ({col, rd_idx[4:0]}), // RQ7
    .raddr_b   (dith_px_addr),
    .rdata_a_q (dith_bus_q),
    .rdata_b_q (dith_px_data)
  );

  // Per colour: four blocks of 64 bytes, block chosen by select
  pattern_mem #(.AW(`FRM_AW), .DEPTH(`FRM_DEPTH)) u_frm_mem (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .we        (frm_we),
    .waddr     ({col, blk, wr_idx[5:0]}), // RQ9 RQ10
    .wdata     (w_data_q[7:0]),
    .raddr_a   ({col, blk, rd_idx[5:0]}), // RQ9 RQ10
    .raddr_b   (frm_px_addr),
    .rdata_a_q (frm_bus_q),
    .rdata_b_q (frm_px_data)
  );

  // ----------------------------------------
  // Read path
  // ----------------------------------------

  // Read data mux, evaluated once the memory byte has settled
  always @* begin
    rdata_d = 32'h0000_0000;
    if (!rd_ok) begin
      rdata_d = 32'h0000_0000;
    end else if (rd_idx == `IDX_CTL) begin
      rdata_d[`CTL_W-1:0] = ctl_q;
    end else if (rd_idx == `IDX_RED) begin
      rdata_d[`SEED_W-1:0] = red_seed; // RQ1
    end else if (rd_idx == `IDX_RED + 8'h01) begin
      rdata_d[6:0] = red_seed[14:8];
    end else if (rd_idx == `IDX_GRN) begin
      rdata_d[`SEED_W-1:0] = green_seed; // RQ2
    end else if (rd_idx == `IDX_GRN + 8'h01) begin
      rdata_d[6:0] = green_seed[14:8];
    end else if (rd_idx == `IDX_BLU) begin
      rdata_d[`SEED_W-1:0] = blue_seed; // RQ3
    end else if (rd_idx == `IDX_BLU + 8'h01) begin
      rdata_d[6:0] = blue_seed[14:8];
    end else if (in_win(rd_idx, `IDX_DITH, `IDX_DITH_E) && col_ok) begin
      rdata_d[7:0] = dith_bus_q; // RQ5
    end else if (in_win(rd_idx, `IDX_FRM, `IDX_FRM_E) && col_ok) begin
      rdata_d[7:0] = frm_bus_q; // RQ8
    end else begin
      // Reserved gaps and unlisted indexes read as zero
      rdata_d = 32'h0000_0000; // RQ11
    end
  end

  // Two-stage read: one edge for the memory, one for the mux
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr_q     <= {`AXI_AW{1'b0}};
      rd_p1_q       <= 1'b0;
      rd_p2_q       <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      rd_p1_q <= 1'b0;
      rd_p2_q <= rd_p1_q;
      if (s_axi_arvalid && s_axi_arready) begin
        // One read at a time; ready stays low until rready
        rd_addr_q     <= s_axi_araddr;
        rd_p1_q       <= 1'b1;
        s_axi_arready <= 1'b0;
      end else if (!s_axi_arready && !rd_p1_q && !rd_p2_q && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (rd_p2_q) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdata_d;
        s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// [tb/lfsr_seed_dither_frm_regs_chk.sv]
`timescale 1ns/1ps
`include "lfsr_seed_dither_frm_defines.vh"
// ----------------------------------------
// Port checker for the seed and pattern block
// ----------------------------------------
module lfsr_seed_dither_frm_regs_chk (
  input wire               aclk,
  input wire               aresetn,
  input wire               s_axi_awvalid,
  input wire               s_axi_awready,
  input wire               s_axi_wvalid,
  input wire               s_axi_wready,
  input wire [1:0]         s_axi_bresp,
  input wire               s_axi_bvalid,
  input wire               s_axi_bready,
  input wire               s_axi_arvalid,
  input wire               s_axi_arready,
  input wire [31:0]        s_axi_rdata,
  input wire               s_axi_rvalid,
  input wire               s_axi_rready,
  input wire [`SEED_W-1:0] red_seed,
  input wire [`SEED_W-1:0] green_seed,
  input wire [`SEED_W-1:0] blue_seed
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read answer: two quiet edges, then data
  sequence rd_wait;
    !s_axi_rvalid [*2] ##1 s_axi_rvalid;
  endsequence
  // Write answer: one quiet edge, then response
  sequence wr_wait;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_red_rst_val: assert property ($rose(aresetn) |-> red_seed == 15'h00AA) else $error("red seed reset");
  a_grn_rst_val: assert property ($rose(aresetn) |-> green_seed == 15'h0032) else $error("green reset");
  a_blu_rst_val: assert property ($rose(aresetn) |-> blue_seed == 15'h0000) else $error("blue reset");
  // Seeds move only as a write response is raised; reserved writes must not
  a_seed_write_only: assert property (!$stable({red_seed, green_seed, blue_seed}) |-> $rose(s_axi_bvalid))
    else $error("seed changed without write");
  a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h00000)
    else $error("upper read bits set");
  a_read_lat_fixed: assert property (s_axi_arvalid && s_axi_arready |=> rd_wait)
    else $error("read latency");
  a_write_lat_fixed: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> wr_wait)
    else $error("write latency");
  a_rdata_held_wait: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bresp_held_wait: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule

bind lfsr_seed_dither_frm_regs lfsr_seed_dither_frm_regs_chk i_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .red_seed, .green_seed, .blue_seed);

// [tb/test_lfsr_seed_dither_frm_regs.sv]
`timescale 1ns/1ps
`include "lfsr_seed_dither_frm_defines.vh"
module test_lfsr_seed_dither_frm_regs;
  // ----------------------------------------
  // Stimulus, responses and model state
  // ----------------------------------------
  reg         aclk, aresetn = 0;
  reg  [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg  [31:0] s_axi_wdata = 0;
  reg  [3:0]  s_axi_wstrb = 0;
  reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  reg  [6:0]  dith_px_addr = 0;
  reg  [9:0]  frm_px_addr = 0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [14:0] red_seed, green_seed, blue_seed;
  wire [7:0]  dith_px_data, frm_px_data;
  reg  [31:0] rs = 32'h2FC0;        // Xorshift state
  int         failures = 0, n_compared = 0, cyc = 0;
  int         sd[3] = '{32'hAA, 32'h32, 32'h0};
  int         ctl = 0;
  int         bp = 0;               // Edges of back-pressure before bready or rready
  int         dm[96];               // Dither bytes, colour * 32 + byte
  int         fm[768];              // Modulation bytes, colour * 256 + block * 64 + byte

  lfsr_seed_dither_frm_regs i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .red_seed, .green_seed, .blue_seed, .dith_px_addr,
    .dith_px_data, .frm_px_addr, .frm_px_data);

  // 50 MHz clock
  initial begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end

  // ----------------------------------------
  // Model, helpers and bus tasks
  // ----------------------------------------
  function automatic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // Model write; odd seed index is a byte view of bits 14:8
  function automatic void mw(input int i, input int d, input int s);
    int k;
    k = (i - 32) / 2;
    if (i >= 32 && i <= 37 && i % 2 == 0) begin
      if (s[0]) sd[k] = (sd[k] & 32'h7F00) | (d & 32'hFF);
      if (s[1]) sd[k] = (sd[k] & 32'hFF) | (d & 32'h7F00);
    end else if (i >= 33 && i <= 37 && s[0]) sd[k] = (sd[k] & 32'hFF) | ((d & 32'h7F) << 8);
    else if (i == 2 && s[0]) ctl = d & 32'hF;
    else if (i >= 128 && i < 160 && s[0] && ctl % 4 != 3) dm[ctl % 4 * 32 + i - 128] = d & 32'hFF;
    else if (i >= 192 && s[0] && ctl % 4 != 3) fm[ctl % 4 * 256 + ctl / 4 * 64 + i - 192] = d & 32'hFF;
  endfunction

  // Model read; colour 3 and reserved places give zero
  function automatic int mr(input int i);
    if (i >= 32 && i <= 37) return (i % 2) ? sd[(i - 32) / 2] >> 8 : sd[(i - 32) / 2];
    if (i == 2) return ctl;
    if (ctl % 4 == 3) return 0;
    if (i >= 128 && i < 160) return dm[ctl % 4 * 32 + i - 128];
    if (i >= 192 && i < 256) return fm[ctl % 4 * 256 + ctl / 4 * 64 + i - 192];
    return 0;
  endfunction

  task automatic chk(input string n, input [31:0] e, input [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Write one word; index above 255 lands outside the decoded space
  task automatic wr(input int i, input [31:0] d, input [3:0] s);
    reg ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= 12'(i * 4);
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    ta = 0;
    tw = 0;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && s_axi_awready === 1'b1) begin
        ta = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!tw && s_axi_wready === 1'b1) begin
        tw = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // A late bready lets the response sit and exercises its hold check
    repeat (bp) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", (i > 255) ? 2 : 0, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
    if (i <= 255) mw(i, d, s);
  endtask

  // Read one word and compare it with the model
  task automatic rd(input int i);
    @(posedge aclk);
    s_axi_araddr <= 12'(i * 4);
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    // A late rready lets the read data sit and exercises its hold check
    repeat (bp) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", mr(i), s_axi_rdata);
    chk("rresp", (i > 255) ? 2 : 0, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
  endtask

  // Seed outputs against the model
  task automatic pchk();
    chk("red_seed", sd[0], {17'h0, red_seed});
    chk("green_seed", sd[1], {17'h0, green_seed});
    chk("blue_seed", sd[2], {17'h0, blue_seed});
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Hang guard: the full run needs about 11000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    int j, c, p;
    int rv[8] = '{0, 1, 3, 31, 38, 127, 160, 191};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (j = 32; j <= 37; j++) rd(j);
    pchk();
    $display("test reset values done");
    // Random seeds, lanes and byte views; bit 15 always written as zero
    for (j = 0; j < 18; j++) begin
      bp = rnd() % 4;
      wr(32 + j % 6, rnd() & ((j % 2) ? 32'h7F : 32'h7FFF), rnd() & 32'hF);
      rd(32 + j % 6);
      pchk();
    end
    bp = 0;
    $display("test seeds done");
    // Reserved places and an undecoded address leave the seeds alone
    for (j = 0; j < 8; j++) begin
      wr(rv[j], rnd(), 4'hF);
      rd(rv[j]);
    end
    wr(256 + 32, 32'h1234, 4'hF);
    rd(256 + 32);
    for (j = 32; j <= 37; j++) rd(j);
    pchk();
    $display("test reserved done");
    // Fill every colour and block, then read all back
    for (p = 0; p < 2; p++) begin
      for (c = 0; c < 16; c++) begin
        wr(2, c, 4'h1);
        for (j = 128; j < 256; j++) begin
          if (j >= 192 || (j < 160 && c < 4)) begin
            if (p == 0) wr(j, rnd() & 32'hFF, 4'h1);
            else rd(j);
          end
        end
      end
    end
    $display("test pattern windows done");
    // Pixel lookups see the same contents one cycle after the address
    for (j = 0; j < 40; j++) begin
      @(posedge aclk);
      dith_px_addr <= 7'(rnd() % 96);
      frm_px_addr <= 10'(rnd());
      repeat (2) @(posedge aclk);
      chk("dith_px", dm[dith_px_addr], {24'h0, dith_px_data});
      chk("frm_px", (frm_px_addr >= 768) ? 0 : fm[frm_px_addr], {24'h0, frm_px_data});
    end
    $display("test pixel lookups done");
    wrap_up();
  end
endmodule
